// file: hdl/pos_ref_scaling.sv
// Position reference, scaling and run protection of a positioning drive
//
// What this block does
// - Direct offset write becomes the reference offset.
// - Actual-value write assigns the value to the present physical position.
// - New offset equals written actual value minus scaled physical position.
// - Derived offset applies at once and reads back as the offset.
// - Offset change recalculates target, actual, mapping end and limits.
// - Increments per rotation are 400 times denominator over numerator.
// - Both scaling factors reset to 400.
// - Each scaling factor is limited to 1 through 10000.
// - No process-data exchange within watchdog time flags connection loss.
// - Connection loss aborts the run and blocks new runs until restored.
// - Run aborts when speed stays below threshold beyond abort time.
// - Stall time defaults to 200 ms, threshold to 30 percent.
// - Running status bit is set while the drive moves.
// - Stall clears running and sets positioning error.
// - Motor supply loss leaves position measurement and stored position.
// - Factor change recalculates all scaled position quantities.
`timescale 1ns/1ps
module pos_ref_scaling
    import pos_ref_pkg::*;
#(
    parameter int MS_DIV = CYC_PER_MS
) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic [POS_W-1:0] phys_pos_i,
    input  wire logic             motor_power_ok_i,
    input  wire logic             offset_wr_i,
    input  wire logic             actual_wr_i,
    input  wire logic             numer_wr_i,
    input  wire logic             denom_wr_i,
    input  wire logic [POS_W-1:0] wr_data_i,
    input  wire logic [POS_W-1:0] target_raw_i,
    input  wire logic [POS_W-1:0] map_end_raw_i,
    input  wire logic [POS_W-1:0] upper_raw_i,
    input  wire logic [POS_W-1:0] lower_raw_i,
    input  wire logic [POS_W-1:0] window_raw_i,
    input  wire logic [POS_W-1:0] loop_raw_i,
    input  wire logic [15:0]      wdog_ms_i,
    input  wire logic             wdog_ms_wr_i,
    input  wire logic             pd_exchange_i,
    input  wire logic [7:0]       stall_pct_i,
    input  wire logic             stall_pct_wr_i,
    input  wire logic [15:0]      stall_ms_i,
    input  wire logic             stall_ms_wr_i,
    input  wire logic             run_start_i,
    input  wire logic             run_done_i,
    input  wire logic [15:0]      speed_i,
    input  wire logic [15:0]      target_speed_i,
    output logic [POS_W-1:0]      offset_o,
    output logic [POS_W-1:0]      actual_o,
    output logic [POS_W-1:0]      target_o,
    output logic [POS_W-1:0]      map_end_o,
    output logic [POS_W-1:0]      upper_o,
    output logic [POS_W-1:0]      lower_o,
    output logic [POS_W-1:0]      window_o,
    output logic [POS_W-1:0]      loop_o,
    output logic [FACT_W-1:0]     numer_o,
    output logic [FACT_W-1:0]     denom_o,
    output logic [FACT_W-1:0]     inc_per_rev_o,
    output logic                  wr_reject_o,
    output logic                  conn_fail_o,
    output logic                  motor_en_o,
    output logic                  running_o,
    output logic                  pos_error_o
);
    // ************************************************************
    // Millisecond tick
    // ************************************************************
    ms_tick_if tick_if ();

    ms_divider #(.DIV(MS_DIV)) u_div (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .tick_if  (tick_if)
    );

    // ************************************************************
    // Offset and scaling factors
    // ************************************************************
    logic [POS_W-1:0]  offset_q, offset_d;
    logic [FACT_W-1:0] numer_q, numer_d;
    logic [FACT_W-1:0] denom_q, denom_d;
    logic              reject_q, reject_d;
    logic              fact_ok;

    // Physical position is an input, never cleared by motor power loss
    assign fact_ok = (wr_data_i >= 32'(FACT_MIN))
                  && (wr_data_i <= 32'(FACT_MAX));

    always_comb begin
        offset_d = offset_q;
        numer_d  = numer_q;
        denom_d  = denom_q;
        reject_d = 1'b0;
        if (numer_wr_i) begin
            if (fact_ok) begin
                numer_d = wr_data_i[FACT_W-1:0];
            end else begin
                reject_d = 1'b1;
            end
        end
        if (denom_wr_i) begin
            if (fact_ok) begin
                denom_d = wr_data_i[FACT_W-1:0];
            end else begin
                reject_d = 1'b1;
            end
        end
        // Physical position in user units, so actual reads the written value
        if (offset_wr_i) begin
            offset_d = wr_data_i;
        end else if (actual_wr_i) begin
            offset_d = wr_data_i
                     - scale(phys_pos_i, numer_d, denom_d);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            offset_q <= OFFSET_RESET;
            numer_q  <= FACT_RESET;
            denom_q  <= FACT_RESET;
            reject_q <= 1'b0;
        end else begin
            offset_q <= offset_d;
            numer_q  <= numer_d;
            denom_q  <= denom_d;
            reject_q <= reject_d;
        end
    end

    // ************************************************************
    // Scaled quantities, recomputed whenever offset or factors change
    // ************************************************************
    function automatic logic [POS_W-1:0] scale(
        input logic [POS_W-1:0]  raw,
        input logic [FACT_W-1:0] num,
        input logic [FACT_W-1:0] den
    );
        logic signed [63:0] p;
        p = 64'(signed'(raw)) * $signed({48'h0, den});
        p = p / $signed({48'h0, num});
        return p[POS_W-1:0];
    endfunction : scale

    logic [POS_W-1:0] actual_d, target_d, map_end_d, upper_d, lower_d;
    logic [POS_W-1:0] window_d, loop_d;
    logic [POS_W-1:0] actual_q, target_q, map_end_q, upper_q, lower_q;
    logic [POS_W-1:0] window_q, loop_q;
    logic [FACT_W-1:0] ipr_d, ipr_q;
    logic [31:0]       ipr_w;

    always_comb begin
        // Offset applies in the same cycle it is stored
        actual_d  = scale(phys_pos_i, numer_d, denom_d)
                  + offset_d;
        target_d  = scale(target_raw_i, numer_d, denom_d)
                  + offset_d;
        map_end_d = scale(map_end_raw_i, numer_d, denom_d)
                  + offset_d;
        upper_d   = scale(upper_raw_i, numer_d, denom_d)
                  + offset_d;
        lower_d   = scale(lower_raw_i, numer_d, denom_d)
                  + offset_d;
        window_d  = scale(window_raw_i, numer_d, denom_d);
        loop_d    = scale(loop_raw_i, numer_d, denom_d);
        ipr_w     = (32'(INC_PER_REV_BASE) * {16'h0, denom_d})
                  / {16'h0, numer_d};
        ipr_d     = ipr_w[FACT_W-1:0];
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            actual_q  <= '0;
            target_q  <= '0;
            map_end_q <= '0;
            upper_q   <= '0;
            lower_q   <= '0;
            window_q  <= '0;
            loop_q    <= '0;
            ipr_q     <= FACT_RESET;
        end else begin
            actual_q  <= actual_d;
            target_q  <= target_d;
            map_end_q <= map_end_d;
            upper_q   <= upper_d;
            lower_q   <= lower_d;
            window_q  <= window_d;
            loop_q    <= loop_d;
            ipr_q     <= ipr_d;
        end
    end

    // ************************************************************
    // Watchdog and stall supervision
    // ************************************************************
    logic [15:0] wdog_lim_q, wdog_lim_d, wdog_cnt_q, wdog_cnt_d;
    logic [7:0]  st_pct_q, st_pct_d;
    logic [15:0] st_lim_q, st_lim_d, st_cnt_q, st_cnt_d;
    logic        fail_q, fail_d;
    logic        slow;
    run_state_t  state_q, state_d;
    logic        perr_q, perr_d;

    // Speed below pct percent of target speed
    assign slow = (32'({16'h0, speed_i}) * 32'd100)
                < (32'({16'h0, target_speed_i}) * 32'({24'h0, st_pct_q}));

    always_comb begin
        wdog_lim_d = wdog_ms_wr_i ? wdog_ms_i : wdog_lim_q;
        st_pct_d   = stall_pct_wr_i ? stall_pct_i : st_pct_q;
        st_lim_d   = stall_ms_wr_i ? stall_ms_i : st_lim_q;
        wdog_cnt_d = wdog_cnt_q;
        fail_d     = fail_q;
        if (pd_exchange_i) begin
            wdog_cnt_d = '0;
            fail_d     = 1'b0;
        end else if (tick_if.tick && !fail_q) begin
            if (wdog_cnt_q + 16'h0001 >= wdog_lim_q) begin
                fail_d = 1'b1;
            end else begin
                wdog_cnt_d = wdog_cnt_q + 16'h0001;
            end
        end
        state_d  = state_q;
        perr_d   = perr_q;
        st_cnt_d = st_cnt_q;
        unique case (state_q)
            RUN_IDLE: begin
                st_cnt_d = '0;
                if (run_start_i && !fail_q) begin
                    state_d = RUN_MOVING;
                    perr_d  = 1'b0;
                end
            end
            RUN_MOVING: begin
                if (fail_q) begin
                    state_d = RUN_IDLE;
                end else if (run_done_i) begin
                    state_d = RUN_IDLE;
                end else if (!slow) begin
                    st_cnt_d = '0;
                end else if (tick_if.tick) begin
                    if (st_cnt_q >= st_lim_q) begin
                        state_d = RUN_FAULT;
                        perr_d  = 1'b1;
                    end else begin
                        st_cnt_d = st_cnt_q + 16'h0001;
                    end
                end
            end
            RUN_FAULT: begin
                state_d = RUN_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wdog_lim_q <= WDOG_MS_RESET;
            st_pct_q   <= STALL_PCT_RESET;
            st_lim_q   <= STALL_MS_RESET;
            wdog_cnt_q <= '0;
            st_cnt_q   <= '0;
            fail_q     <= 1'b0;
            state_q    <= RUN_IDLE;
            perr_q     <= 1'b0;
        end else begin
            wdog_lim_q <= wdog_lim_d;
            st_pct_q   <= st_pct_d;
            st_lim_q   <= st_lim_d;
            wdog_cnt_q <= wdog_cnt_d;
            st_cnt_q   <= st_cnt_d;
            fail_q     <= fail_d;
            state_q    <= state_d;
            perr_q     <= perr_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign offset_o      = offset_q;
    assign actual_o      = actual_q;
    assign target_o      = target_q;
    assign map_end_o     = map_end_q;
    assign upper_o       = upper_q;
    assign lower_o       = lower_q;
    assign window_o      = window_q;
    assign loop_o        = loop_q;
    assign numer_o       = numer_q;
    assign denom_o       = denom_q;
    assign inc_per_rev_o = ipr_q;
    assign wr_reject_o   = reject_q;
    assign conn_fail_o   = fail_q;
    assign running_o     = (state_q == RUN_MOVING);
    assign motor_en_o    = running_o && motor_power_ok_i;
    assign pos_error_o   = perr_q;
endmodule : pos_ref_scaling

// file: hdl/pos_ref_pkg.sv
// Constants and types for the position reference and scaling block
package pos_ref_pkg;

    localparam int          POS_W            = 32;
    localparam int          FACT_W           = 16;
    localparam int          INC_PER_REV_BASE = 400;
    localparam logic [15:0] FACT_RESET       = 16'h0190;
    localparam logic [15:0] FACT_MIN         = 16'h0001;
    localparam logic [15:0] FACT_MAX         = 16'h2710;
    localparam logic [31:0] OFFSET_RESET     = 32'h0000_0000;
    localparam logic [7:0]  STALL_PCT_RESET  = 8'h1e;
    localparam logic [15:0] STALL_MS_RESET   = 16'h00c8;
    localparam logic [15:0] WDOG_MS_RESET    = 16'h0064;
    localparam int          CLK_MHZ          = 100;
    localparam int          MS_NS            = 1000000;
    localparam int          CLK_NS           = 1000 / CLK_MHZ;
    localparam int          CYC_PER_MS       = MS_NS / CLK_NS;

    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_MOVING,
        RUN_FAULT
    } run_state_t;

endpackage : pos_ref_pkg

// file: hdl/ms_tick_if.sv
// Millisecond tick shared between the divider and the block
`timescale 1ns/1ps
interface ms_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input  tick);
endinterface : ms_tick_if

// file: hdl/ms_divider.sv
// Divider giving a one-cycle pulse every millisecond
`timescale 1ns/1ps
module ms_divider
    import pos_ref_pkg::*;
#(
    parameter int DIV = CYC_PER_MS
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    ms_tick_if.src    tick_if
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic        tick_q;
    logic        tick_d;

    always_comb begin
        tick_d = 1'b0;
        cnt_d  = cnt_q + 32'h0000_0001;
        if (cnt_q >= 32'(DIV - 1)) begin
            cnt_d  = 32'h0000_0000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt_q  <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_if.tick = tick_q;
endmodule : ms_divider

// file: tb/pd_master_model.sv
// Bus master model issuing periodic process-data exchanges
`timescale 1ns/1ps
module pd_master_model #(
    parameter int PERIOD = 20
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic en_i,
    output logic      pd_exchange_o
);
    int cnt_q;
    // Cadence kept well inside the watchdog time; silent while disabled
    always_ff @(posedge clk_i) begin
        if (!resetn_i || cnt_q == PERIOD - 1) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= cnt_q + 1;
        end
        pd_exchange_o <= resetn_i && en_i && cnt_q == PERIOD - 1;
    end
endmodule : pd_master_model

// file: tb/pos_ref_asserts.sv
// Port-level assertions for the position reference block
`timescale 1ns/1ps
module pos_ref_asserts
    import pos_ref_pkg::*;
#(
    parameter int MS_DIV = CYC_PER_MS
) (
    input wire logic              clk_i,
    input wire logic              resetn_i,
    input wire logic [POS_W-1:0]  phys_pos_i,
    input wire logic              motor_power_ok_i,
    input wire logic              offset_wr_i,
    input wire logic              actual_wr_i,
    input wire logic              numer_wr_i,
    input wire logic [POS_W-1:0]  wr_data_i,
    input wire logic              run_start_i,
    input wire logic [POS_W-1:0]  offset_o,
    input wire logic [FACT_W-1:0] numer_o,
    input wire logic [FACT_W-1:0] denom_o,
    input wire logic [FACT_W-1:0] inc_per_rev_o,
    input wire logic              wr_reject_o,
    input wire logic              conn_fail_o,
    input wire logic              motor_en_o,
    input wire logic              running_o,
    input wire logic              pos_error_o
);
    sequence s_bad_numer;
        numer_wr_i && (wr_data_i == 32'h0 || wr_data_i > {16'h0, FACT_MAX});
    endsequence
    sequence s_refused;
        wr_reject_o && $stable(numer_o);
    endsequence
    property p_refuse;
        @(posedge clk_i) disable iff (!resetn_i) s_bad_numer |=> s_refused;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("bad factor write not refused");
    property p_offset_wr;
        @(posedge clk_i) disable iff (!resetn_i)
        offset_wr_i |=> offset_o == $past(wr_data_i);
    endproperty
    a_offset_wr: assert property (p_offset_wr)
        else $error("offset write not adopted");
    property p_actual_wr;
        @(posedge clk_i) disable iff (!resetn_i)
        actual_wr_i && !offset_wr_i && numer_o == denom_o
        |=> offset_o == $past(wr_data_i) - $past(phys_pos_i);
    endproperty
    a_actual_wr: assert property (p_actual_wr)
        else $error("derived offset wrong");
    property p_reset;
        @(posedge clk_i) !resetn_i |=> numer_o == FACT_RESET
        && denom_o == FACT_RESET && inc_per_rev_o == 16'h0190
        && offset_o == OFFSET_RESET && !running_o && !pos_error_o;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset values wrong");
    property p_range;
        @(posedge clk_i) disable iff (!resetn_i)
        numer_o >= FACT_MIN && numer_o <= FACT_MAX
        && denom_o >= FACT_MIN && denom_o <= FACT_MAX;
    endproperty
    a_range: assert property (p_range)
        else $error("factor out of range");
    property p_inc;
        @(posedge clk_i) disable iff (!resetn_i)
        inc_per_rev_o == 16'(32'h190 * denom_o / numer_o);
    endproperty
    a_inc: assert property (p_inc)
        else $error("increments per rotation wrong");
    property p_start;
        @(posedge clk_i) disable iff (!resetn_i)
        run_start_i && !conn_fail_o && !running_o |=> running_o;
    endproperty
    a_start: assert property (p_start)
        else $error("run not started");
    property p_conn_abort;
        @(posedge clk_i) disable iff (!resetn_i) conn_fail_o |=> !running_o;
    endproperty
    a_conn_abort: assert property (p_conn_abort)
        else $error("run kept during connection loss");
    property p_stall;
        @(posedge clk_i) disable iff (!resetn_i)
        $rose(pos_error_o) |-> $fell(running_o);
    endproperty
    a_stall: assert property (p_stall)
        else $error("stall error without run stop");
    property p_motor;
        @(posedge clk_i) disable iff (!resetn_i)
        motor_en_o == (running_o && motor_power_ok_i);
    endproperty
    a_motor: assert property (p_motor)
        else $error("motor enable wrong");
endmodule : pos_ref_asserts
bind pos_ref_scaling pos_ref_asserts #(.MS_DIV(MS_DIV)) pos_ref_asserts_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .phys_pos_i(phys_pos_i),
    .motor_power_ok_i(motor_power_ok_i), .offset_wr_i(offset_wr_i),
    .actual_wr_i(actual_wr_i), .numer_wr_i(numer_wr_i),
    .wr_data_i(wr_data_i), .run_start_i(run_start_i), .offset_o(offset_o),
    .numer_o(numer_o), .denom_o(denom_o), .inc_per_rev_o(inc_per_rev_o),
    .wr_reject_o(wr_reject_o), .conn_fail_o(conn_fail_o),
    .motor_en_o(motor_en_o), .running_o(running_o), .pos_error_o(pos_error_o)
);

// file: tb/tb_top.sv
// Testbench for the position reference and scaling block
`timescale 1ns/1ps
module tb_top
    import pos_ref_pkg::*;
;
    logic clk_i = 1'b0;
    logic resetn_i, motor_power_ok_i, pd_exchange_i, pd_en;
    logic offset_wr_i, actual_wr_i, numer_wr_i, denom_wr_i;
    logic wdog_ms_wr_i, stall_pct_wr_i, stall_ms_wr_i, run_start_i, run_done_i;
    logic [POS_W-1:0]  phys_pos_i, wr_data_i, target_raw_i, map_end_raw_i;
    logic [POS_W-1:0]  upper_raw_i, lower_raw_i, window_raw_i, loop_raw_i;
    logic [POS_W-1:0]  offset_o, actual_o, target_o, map_end_o, upper_o;
    logic [POS_W-1:0]  lower_o, window_o, loop_o;
    logic [15:0]       wdog_ms_i, stall_ms_i, speed_i, target_speed_i;
    logic [7:0]        stall_pct_i;
    logic [FACT_W-1:0] numer_o, denom_o, inc_per_rev_o;
    logic wr_reject_o, conn_fail_o, motor_en_o, running_o, pos_error_o;
    int   mismatches = 0;
    int   checks = 0;
    always #5 clk_i = ~clk_i;
    pos_ref_scaling #(.MS_DIV(10)) pos_ref_scaling_i (.clk_i, .resetn_i,
        .phys_pos_i, .motor_power_ok_i, .offset_wr_i, .actual_wr_i,
        .numer_wr_i, .denom_wr_i, .wr_data_i, .target_raw_i, .map_end_raw_i,
        .upper_raw_i, .lower_raw_i, .window_raw_i, .loop_raw_i, .wdog_ms_i,
        .wdog_ms_wr_i, .pd_exchange_i, .stall_pct_i, .stall_pct_wr_i,
        .stall_ms_i, .stall_ms_wr_i, .run_start_i, .run_done_i, .speed_i,
        .target_speed_i, .offset_o, .actual_o, .target_o, .map_end_o,
        .upper_o, .lower_o, .window_o, .loop_o, .numer_o, .denom_o,
        .inc_per_rev_o, .wr_reject_o, .conn_fail_o, .motor_en_o, .running_o,
        .pos_error_o);
    pd_master_model pd_master_model_i (.clk_i, .resetn_i, .en_i(pd_en),
        .pd_exchange_o(pd_exchange_i));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, exp, input string msg);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask : chk
    task automatic wr(input int sel, input logic [31:0] d);
        @(posedge clk_i);
        wr_data_i <= d;
        wdog_ms_i <= d[15:0];
        stall_ms_i <= d[15:0];
        stall_pct_i <= d[7:0];
        case (sel)
            0: offset_wr_i <= 1'b1;
            1: actual_wr_i <= 1'b1;
            2: numer_wr_i <= 1'b1;
            3: denom_wr_i <= 1'b1;
            4: wdog_ms_wr_i <= 1'b1;
            5: stall_pct_wr_i <= 1'b1;
            default: stall_ms_wr_i <= 1'b1;
        endcase
        @(posedge clk_i);
        {offset_wr_i, actual_wr_i, numer_wr_i, denom_wr_i} <= 4'h0;
        {wdog_ms_wr_i, stall_pct_wr_i, stall_ms_wr_i} <= 3'h0;
        #1;
    endtask : wr
    task automatic pulse(input bit done);
        @(posedge clk_i);
        run_start_i <= !done;
        run_done_i <= done;
        @(posedge clk_i);
        {run_start_i, run_done_i} <= 2'h0;
        #1;
    endtask : pulse
    function automatic logic pick(input int w);
        return w == 0 ? conn_fail_o : pos_error_o;
    endfunction : pick
    task automatic wait_for(input int w, input logic v, input int lim,
                            output int n);
        n = 0;
        while (pick(w) !== v && n < lim) begin
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask : wait_for
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        @(posedge clk_i);
        resetn_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk(numer_o, 32'h190, "numer reset");
        chk(denom_o, 32'h190, "denom reset");
        chk(inc_per_rev_o, 32'h190, "inc reset");
        chk(window_o, window_raw_i, "unit scale");
        $display("test reset done");
    endtask : t_reset
    task automatic t_ref();
        wr(0, 32'h100);
        chk(offset_o, 32'h100, "offset");
        chk(target_o, target_raw_i + 32'h100, "target");
        chk(map_end_o, map_end_raw_i + 32'h100, "map end");
        chk(upper_o, upper_raw_i + 32'h100, "upper");
        chk(lower_o, lower_raw_i + 32'h100, "lower");
        wr(1, 32'h64);
        chk(offset_o, 32'h64 - phys_pos_i, "derived offset");
        chk(actual_o, 32'h64, "actual");
        chk(target_o, target_raw_i + 32'h64 - phys_pos_i, "target");
        $display("test reference done");
    endtask : t_ref
    task automatic t_scale();
        wr(3, 32'h64);
        chk(inc_per_rev_o, 32'h64, "inc denom");
        chk(window_o, 32'hc8, "window scaled");
        chk(loop_o, 32'h19, "loop scaled");
        wr(1, 32'h64);
        chk(actual_o, 32'h64, "scaled actual");
        chk(offset_o, 32'h64 - 32'hfa, "scaled offset");
        wr(2, 32'h0);
        chk({wr_reject_o, numer_o}, 32'h1_0190, "zero refused");
        wr(2, 32'h2711);
        chk({wr_reject_o, numer_o}, 32'h1_0190, "big refused");
        wr(3, 32'h2711);
        chk({wr_reject_o, denom_o}, 32'h1_0064, "big denom");
        wr(2, 32'h2710);
        chk({wr_reject_o, numer_o}, 32'h2710, "max numer");
        chk(inc_per_rev_o, 32'h4, "inc both");
        chk(window_o, 32'h8, "window rescaled");
        wr(2, 32'h190);
        wr(3, 32'h190);
        wr(1, 32'h64);
        $display("test scale done");
    endtask : t_scale
    task automatic t_wdog();
        int n;
        wr(4, 32'h5);
        pulse(0);
        chk(running_o, 1'b1, "running");
        @(posedge clk_i);
        pd_en <= 1'b0;
        wait_for(0, 1'b1, 100, n);
        chk(n >= 15 && n <= 75, 1'b1, "silence time");
        @(posedge clk_i);
        #1;
        chk({running_o, pos_error_o}, 32'h0, "aborted");
        pulse(0);
        chk(running_o, 1'b0, "start refused");
        @(posedge clk_i);
        pd_en <= 1'b1;
        wait_for(0, 1'b0, 40, n);
        pulse(0);
        chk(running_o, 1'b1, "restored");
        pulse(1);
        chk(running_o, 1'b0, "done");
        $display("test watchdog done");
    endtask : t_wdog
    task automatic t_stall();
        int n;
        wr(6, 32'h3);
        speed_i <= 16'h0028;
        pulse(0);
        wait_for(1, 1'b1, 80, n);
        chk({running_o, pos_error_o}, 32'h2, "above 30 pct");
        @(posedge clk_i);
        motor_power_ok_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(actual_o, 32'h64, "position kept");
        chk(motor_en_o, 1'b0, "motor off");
        @(posedge clk_i);
        motor_power_ok_i <= 1'b1;
        wr(5, 32'h3c);
        wait_for(1, 1'b1, 80, n);
        chk(n >= 15 && n <= 50, 1'b1, "stall time");
        chk({running_o, pos_error_o}, 32'h1, "stalled");
        chk($signed(actual_o) < $signed(upper_o), 1'b1, "inside limit");
        $display("test stall done");
    endtask : t_stall
    initial begin
        resetn_i = 1'b0;
        motor_power_ok_i = 1'b1;
        pd_en = 1'b1;
        {offset_wr_i, actual_wr_i, numer_wr_i, denom_wr_i} = 4'h0;
        {wdog_ms_wr_i, stall_pct_wr_i, stall_ms_wr_i} = 3'h0;
        {run_start_i, run_done_i} = 2'h0;
        {phys_pos_i, wr_data_i} = {32'h3e8, 32'h0};
        {target_raw_i, map_end_raw_i} = {32'h1000, 32'h000c_4fa0};
        {upper_raw_i, lower_raw_i} = {32'h000c_4950, -32'h000c_4950};
        {window_raw_i, loop_raw_i} = {32'h320, 32'h64};
        {wdog_ms_i, stall_ms_i, stall_pct_i} = 40'h0;
        {speed_i, target_speed_i} = {16'h0064, 16'h0064};
        t_reset();
        t_ref();
        t_scale();
        t_wdog();
        t_stall();
        wr(3, 32'h64);
        t_reset();
        report_and_stop();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        $display("MISMATCH t=%0t run did not finish", $time);
        report_and_stop();
    end
endmodule : tb_top
